// >>> rtl/wlf_top.sv
// Wake/link status and wake-frame filter control with a classic Wishbone slave.
//
// Overview of operation
// - Link change sets bit 0; read clears.
// - Bit 1 shows current link state.
// - Magic packet wake sets bit 4; read clears.
// - External pin wake sets bit 5; read clears.
// - Pattern frame wake sets bit 6; read clears.
// - Command bit 0 enables filter A.
// - Command bit 2 enables filter B.
// - Unicast bit demands destination equals station address, except A's under cascade.
// - Unicast bit clear accepts any destination.
// - Cascade bit merges filters, uses B's CRC.
// - With cascade, filter B starts after A's window plus offset.
// - Without cascade, either filter qualifies a frame.
// - Match needs CRC and last byte equal.
// - Offset unit is two bytes from destination.
// - 32-bit mask, one bit per byte.
// - Enabled wake events raise wake interrupt.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "wlf_defs.svh"

module wlf_top #(
  parameter int ADDR_W = 9
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive byte stream from the MAC.
  input wire logic rx_sof_i,
  input wire logic rx_valid_i,
  input wire wlf_pkg::wlf_byte_t rx_data_i,
  input wire logic rx_eof_i,
  // Wake sources.
  input wire logic magic_detect_i,
  input wire logic external_wake_pin_i,
  input wire logic link_up_i,
  // Interrupt lines.
  output logic wake_irq_o,
  output logic link_irq_o
);
  import wlf_pkg::*;

  // --------------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------------
  wlf_byte_t wake_irq_enable_reg;
  wlf_byte_t link_irq_enable_reg;
  wlf_byte_t filter_command_reg;
  wlf_mask_t filter_a_byte_mask_reg;
  wlf_mask_t filter_b_byte_mask_reg;
  wlf_crc_t filter_a_crc_reg;
  wlf_crc_t filter_b_crc_reg;
  wlf_byte_t filter_a_offset_reg;
  wlf_byte_t filter_b_offset_reg;
  wlf_byte_t filter_a_last_byte_reg;
  wlf_byte_t filter_b_last_byte_reg;
  logic [47:0] station_mac_address_reg;
  logic link_change_event_reg;
  logic magic_wake_event_reg;
  logic pin_wake_event_reg;
  logic pattern_wake_event_reg;
  logic [31:0] rd_next;

  // --------------------------------------------------------------------------
  // Bus decode.
  // --------------------------------------------------------------------------
  logic [`WLF_IDX_W-1:0] idx;
  logic req;
  logic wr;
  logic rd_status;

  assign idx = wb_adr_i[ADDR_W-1:2];
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign rd_status = req && !wb_we_i && (idx == `WLF_IDX_STATUS);
  // Merges the enabled byte lanes of a write into a 32-bit value.
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : lanes
  // Acknowledges every access one cycle after the strobe, then drops it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req && !wb_we_i ? rd_next : 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Link state sampling and pin synchroniser.
  // --------------------------------------------------------------------------
  logic link_meta_reg;
  logic link_sync_reg;
  logic link_prev_reg;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;
  logic link_change;
  logic pin_rise;
  // Brings the asynchronous link level and wake pin into the clock domain.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_meta_reg <= 1'b0;
      link_sync_reg <= 1'b0;
      link_prev_reg <= 1'b0;
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      link_meta_reg <= link_up_i;
      link_sync_reg <= link_meta_reg;
      link_prev_reg <= link_sync_reg;
      pin_meta_reg <= external_wake_pin_i;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign link_change = link_sync_reg != link_prev_reg;
  assign pin_rise = pin_sync_reg && !pin_prev_reg;
  // --------------------------------------------------------------------------
  // Frame tracking and destination check.
  // --------------------------------------------------------------------------
  wlf_index_t byte_idx_reg;
  logic da_ok_reg;
  wlf_byte_t mac_byte;
  logic [2:0] da_pos;

  assign da_pos = byte_idx_reg[2:0];
  assign mac_byte = station_mac_address_reg[8'(47 - 8 * da_pos) -: 8];

  // Counts frame bytes from the first destination byte and checks the address.
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_sof_i) begin
      byte_idx_reg <= 11'h000;
      da_ok_reg <= 1'b1;
    end else if (rx_valid_i) begin
      if (byte_idx_reg < `WLF_DA_LEN && rx_data_i != mac_byte) begin
        da_ok_reg <= 1'b0;
      end
      if (byte_idx_reg != `WLF_IDX_MAX) begin
        byte_idx_reg <= byte_idx_reg + 11'h001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pattern filters.
  // --------------------------------------------------------------------------
  logic cascade;
  wlf_index_t a_start;
  wlf_index_t b_start;
  wlf_crc_t a_crc;
  logic a_match;
  logic b_match;
  logic a_hit;
  logic b_hit;
  logic pattern_hit;
  assign cascade = filter_command_reg[`WLF_CMD_CASCADE];
  assign a_start = {2'b00, filter_a_offset_reg, 1'b0};
  // Cascaded filter B begins after A's 32 bytes plus its own offset.
  assign b_start = (cascade ? a_start + `WLF_WINDOW_LEN : 11'h000)
                   + {2'b00, filter_b_offset_reg, 1'b0};
  wlf_filter u_filter_a (
    .clk_i(clk_i), .rst_i(rst_i), .frame_start_i(rx_sof_i), .byte_valid_i(rx_valid_i),
    .byte_data_i(rx_data_i), .byte_index_i(byte_idx_reg), .start_i(a_start),
    .mask_i(filter_a_byte_mask_reg), .crc_prog_i(filter_a_crc_reg),
    .last_prog_i(filter_a_last_byte_reg), .chain_i(1'b0), .chain_crc_i(`WLF_CRC_INIT),
    .crc_o(a_crc), .match_o(a_match)
  );
  wlf_filter u_filter_b (
    .clk_i(clk_i), .rst_i(rst_i), .frame_start_i(rx_sof_i), .byte_valid_i(rx_valid_i),
    .byte_data_i(rx_data_i), .byte_index_i(byte_idx_reg), .start_i(b_start),
    .mask_i(filter_b_byte_mask_reg), .crc_prog_i(filter_b_crc_reg),
    .last_prog_i(filter_b_last_byte_reg), .chain_i(cascade), .chain_crc_i(a_crc),
    .crc_o(), .match_o(b_match)
  );
  // Qualifies each filter with its enable and unicast setting.
  assign a_hit = filter_command_reg[`WLF_CMD_A_EN] && a_match
                 && (!filter_command_reg[`WLF_CMD_A_UNI] || da_ok_reg);
  assign b_hit = filter_command_reg[`WLF_CMD_B_EN] && b_match
                 && (!filter_command_reg[`WLF_CMD_B_UNI] || da_ok_reg);
  // Cascade checks only the merged result; otherwise either filter suffices.
  assign pattern_hit = rx_eof_i && (cascade
                       ? (b_hit && filter_command_reg[`WLF_CMD_A_EN])
                       : (a_hit || b_hit));

  // --------------------------------------------------------------------------
  // Event flags; a new event wins over the clearing read.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_change_event_reg <= 1'b0;
      magic_wake_event_reg <= 1'b0;
      pin_wake_event_reg <= 1'b0;
      pattern_wake_event_reg <= 1'b0;
    end else begin
      if (link_change) begin
        link_change_event_reg <= 1'b1;
      end else if (rd_status) begin
        link_change_event_reg <= 1'b0;
      end
      if (magic_detect_i && wake_irq_enable_reg[`WLF_WE_MAGIC]) begin
        magic_wake_event_reg <= 1'b1;
      end else if (rd_status) begin
        magic_wake_event_reg <= 1'b0;
      end
      if (pin_rise && wake_irq_enable_reg[`WLF_WE_PIN]) begin
        pin_wake_event_reg <= 1'b1;
      end else if (rd_status) begin
        pin_wake_event_reg <= 1'b0;
      end
      if (pattern_hit && wake_irq_enable_reg[`WLF_WE_PATTERN]) begin
        pattern_wake_event_reg <= 1'b1;
      end else if (rd_status) begin
        pattern_wake_event_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt lines driven from the flags.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_irq_o <= 1'b0;
      link_irq_o <= 1'b0;
    end else begin
      wake_irq_o <= magic_wake_event_reg || pin_wake_event_reg || pattern_wake_event_reg
                    || (link_change_event_reg && link_sync_reg
                        && wake_irq_enable_reg[`WLF_WE_LINKUP]);
      link_irq_o <= link_change_event_reg && link_irq_enable_reg[0];
    end
  end

  // --------------------------------------------------------------------------
  // Software-written registers.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_irq_enable_reg <= `WLF_RST_BYTE;
      link_irq_enable_reg <= `WLF_RST_BYTE;
      filter_command_reg <= `WLF_RST_BYTE;
      filter_a_byte_mask_reg <= `WLF_RST_MASK;
      filter_b_byte_mask_reg <= `WLF_RST_MASK;
      filter_a_crc_reg <= `WLF_RST_CRC;
      filter_b_crc_reg <= `WLF_RST_CRC;
      filter_a_offset_reg <= `WLF_RST_BYTE;
      filter_b_offset_reg <= `WLF_RST_BYTE;
      filter_a_last_byte_reg <= `WLF_RST_BYTE;
      filter_b_last_byte_reg <= `WLF_RST_BYTE;
      station_mac_address_reg <= `WLF_RST_MAC;
    end else if (wr && wb_sel_i[0]) begin
      unique case (idx)
        `WLF_IDX_WAKE_EN: wake_irq_enable_reg <= wb_dat_i[7:0] & `WLF_WE_MASK;
        `WLF_IDX_LINK_EN: link_irq_enable_reg <= wb_dat_i[7:0] & `WLF_LE_MASK;
        `WLF_IDX_CMD: filter_command_reg <= wb_dat_i[7:0] & `WLF_CMD_MASK;
        `WLF_IDX_A_OFF: filter_a_offset_reg <= wb_dat_i[7:0];
        `WLF_IDX_B_OFF: filter_b_offset_reg <= wb_dat_i[7:0];
        `WLF_IDX_A_LB: filter_a_last_byte_reg <= wb_dat_i[7:0];
        `WLF_IDX_B_LB: filter_b_last_byte_reg <= wb_dat_i[7:0];
        default: ;
      endcase
    end
    if (!rst_i && wr) begin
      unique case (idx)
        `WLF_IDX_A_MASK: filter_a_byte_mask_reg <=
          lanes(filter_a_byte_mask_reg, wb_dat_i, wb_sel_i);
        `WLF_IDX_B_MASK: filter_b_byte_mask_reg <=
          lanes(filter_b_byte_mask_reg, wb_dat_i, wb_sel_i);
        `WLF_IDX_A_CRC: filter_a_crc_reg <=
          16'(lanes({16'h0000, filter_a_crc_reg}, wb_dat_i, wb_sel_i));
        `WLF_IDX_B_CRC: filter_b_crc_reg <=
          16'(lanes({16'h0000, filter_b_crc_reg}, wb_dat_i, wb_sel_i));
        `WLF_IDX_MAC_LO: station_mac_address_reg[31:0] <=
          lanes(station_mac_address_reg[31:0], wb_dat_i, wb_sel_i);
        `WLF_IDX_MAC_HI: station_mac_address_reg[47:32] <=
          16'(lanes({16'h0000, station_mac_address_reg[47:32]}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Read multiplexer; unmapped words read as zero.
  // --------------------------------------------------------------------------
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (idx)
      `WLF_IDX_WAKE_EN: rd_next[7:0] = wake_irq_enable_reg;
      `WLF_IDX_LINK_EN: rd_next[7:0] = link_irq_enable_reg;
      `WLF_IDX_STATUS: begin
        rd_next[`WLF_ST_LINK_CHG] = link_change_event_reg;
        rd_next[`WLF_ST_LINK_UP] = link_sync_reg;
        rd_next[`WLF_ST_MAGIC] = magic_wake_event_reg;
        rd_next[`WLF_ST_PIN] = pin_wake_event_reg;
        rd_next[`WLF_ST_PATTERN] = pattern_wake_event_reg;
      end
      `WLF_IDX_CMD: rd_next[7:0] = filter_command_reg;
      `WLF_IDX_A_MASK: rd_next = filter_a_byte_mask_reg;
      `WLF_IDX_B_MASK: rd_next = filter_b_byte_mask_reg;
      `WLF_IDX_A_CRC: rd_next[15:0] = filter_a_crc_reg;
      `WLF_IDX_B_CRC: rd_next[15:0] = filter_b_crc_reg;
      `WLF_IDX_A_OFF: rd_next[7:0] = filter_a_offset_reg;
      `WLF_IDX_B_OFF: rd_next[7:0] = filter_b_offset_reg;
      `WLF_IDX_A_LB: rd_next[7:0] = filter_a_last_byte_reg;
      `WLF_IDX_B_LB: rd_next[7:0] = filter_b_last_byte_reg;
      `WLF_IDX_MAC_LO: rd_next = station_mac_address_reg[31:0];
      `WLF_IDX_MAC_HI: rd_next[15:0] = station_mac_address_reg[47:32];
      default: rd_next = 32'h0000_0000;
    endcase
  end
endmodule : wlf_top

// >>> rtl/wlf_defs.svh
// Register indices, field positions, reset values and constants of the wake/filter block.
`ifndef WLF_DEFS_SVH
`define WLF_DEFS_SVH

// ----------------------------------------------------------------------------
// Register word indices (byte address is four times the index).
// ----------------------------------------------------------------------------
`define WLF_IDX_W 7
`define WLF_IDX_WAKE_EN 7'h24
`define WLF_IDX_LINK_EN 7'h26
`define WLF_IDX_STATUS 7'h28
`define WLF_IDX_CMD 7'h30
`define WLF_IDX_A_MASK 7'h32
`define WLF_IDX_A_CRC 7'h36
`define WLF_IDX_A_OFF 7'h38
`define WLF_IDX_A_LB 7'h3A
`define WLF_IDX_B_MASK 7'h40
`define WLF_IDX_B_CRC 7'h44
`define WLF_IDX_B_OFF 7'h46
`define WLF_IDX_B_LB 7'h48
`define WLF_IDX_MAC_LO 7'h50
`define WLF_IDX_MAC_HI 7'h51

// ----------------------------------------------------------------------------
// Status register fields.
// ----------------------------------------------------------------------------
`define WLF_ST_LINK_CHG 0
`define WLF_ST_LINK_UP 1
`define WLF_ST_MAGIC 4
`define WLF_ST_PIN 5
`define WLF_ST_PATTERN 6

// ----------------------------------------------------------------------------
// Filter command register fields.
// ----------------------------------------------------------------------------
`define WLF_CMD_A_EN 0
`define WLF_CMD_A_UNI 1
`define WLF_CMD_B_EN 2
`define WLF_CMD_B_UNI 3
`define WLF_CMD_CASCADE 4
`define WLF_CMD_MASK 8'h1F

// ----------------------------------------------------------------------------
// Wake enable fields.
// ----------------------------------------------------------------------------
`define WLF_WE_LINKUP 0
`define WLF_WE_MAGIC 4
`define WLF_WE_PIN 5
`define WLF_WE_PATTERN 6
`define WLF_WE_MASK 8'h71
`define WLF_LE_MASK 8'h01

// ----------------------------------------------------------------------------
// Reset values and frame constants.
// ----------------------------------------------------------------------------
`define WLF_RST_BYTE 8'h00
`define WLF_RST_CRC 16'h0000
`define WLF_RST_MASK 32'h0000_0000
`define WLF_RST_MAC 48'h0000_0000_0000
`define WLF_CRC_POLY 16'h8005
`define WLF_CRC_INIT 16'hFFFF
`define WLF_WINDOW_LEN 11'h020
`define WLF_DA_LEN 11'h006
`define WLF_IDX_MAX 11'h7FF
`define WLF_BYTE_W 8

`endif

// >>> rtl/wlf_pkg.sv
// Types shared by the wake/filter block.
package wlf_pkg;
  typedef logic [7:0] wlf_byte_t;
  typedef logic [15:0] wlf_crc_t;
  typedef logic [31:0] wlf_mask_t;
  typedef logic [10:0] wlf_index_t;
endpackage : wlf_pkg

// >>> rtl/wlf_filter.sv
// One pattern filter: masked CRC-16 and last masked byte over a 32-byte window.
`timescale 1ns/1ps
`include "wlf_defs.svh"

module wlf_filter (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Byte stream.
  input wire logic frame_start_i,
  input wire logic byte_valid_i,
  input wire wlf_pkg::wlf_byte_t byte_data_i,
  input wire wlf_pkg::wlf_index_t byte_index_i,
  // Filter program.
  input wire wlf_pkg::wlf_index_t start_i,
  input wire wlf_pkg::wlf_mask_t mask_i,
  input wire wlf_pkg::wlf_crc_t crc_prog_i,
  input wire wlf_pkg::wlf_byte_t last_prog_i,
  // Chaining from a preceding filter.
  input wire logic chain_i,
  input wire wlf_pkg::wlf_crc_t chain_crc_i,
  // Results.
  output wlf_pkg::wlf_crc_t crc_o,
  output logic match_o
);
  import wlf_pkg::*;

  wlf_crc_t crc_reg;
  wlf_byte_t last_reg;
  logic used_reg;
  wlf_index_t rel;
  logic in_window;
  logic take;
  wlf_crc_t crc_cur;
  wlf_crc_t crc_next;

  // Advances a CRC-16 by one byte, most significant bit first.
  function automatic wlf_crc_t crc_step(input wlf_crc_t c, input wlf_byte_t d);
    wlf_crc_t r;
    logic fb;
    r = c;
    for (int i = `WLF_BYTE_W - 1; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ `WLF_CRC_POLY;
      end
    end
    return r;
  endfunction : crc_step

  // Window position and mask selection; each mask bit covers one frame byte.
  assign rel = wlf_index_t'(byte_index_i - start_i);
  assign in_window = (byte_index_i >= start_i) && (rel < `WLF_WINDOW_LEN);
  assign take = byte_valid_i && in_window && mask_i[rel[4:0]];
  // A chained filter carries the earlier filter's CRC until it takes a byte.
  assign crc_cur = (chain_i && !used_reg) ? chain_crc_i : crc_reg;
  assign crc_next = crc_step(crc_cur, byte_data_i);
  assign crc_o = crc_cur;
  assign match_o = (crc_cur == crc_prog_i) && (last_reg == last_prog_i);

  // Accumulates CRC and remembers the last masked byte.
  always_ff @(posedge clk_i) begin
    if (rst_i || frame_start_i) begin
      crc_reg <= `WLF_CRC_INIT;
      last_reg <= `WLF_RST_BYTE;
      used_reg <= 1'b0;
    end else if (take) begin
      crc_reg <= crc_next;
      last_reg <= byte_data_i;
      used_reg <= 1'b1;
    end
  end
endmodule : wlf_filter

// >>> bench/wlf_top_checker.sv
// Concurrent checks on the ports of the wake/filter top.
`timescale 1ns/1ps
`include "wlf_defs.svh"

module wlf_top_checker #(
  parameter int ADDR_W = 9
) (
  // Clock, reset and Wishbone.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Wake sources and interrupt lines.
  input wire logic magic_detect_i,
  input wire logic external_wake_pin_i,
  input wire logic link_up_i,
  input wire logic wake_irq_o,
  input wire logic link_irq_o
);
  import wlf_pkg::*;
  logic take;
  logic take_st;
  logic take_len;
  logic [7:0] wen_q;
  logic [7:0] len_q;

  // ----
  // Helper logic
  // ----
  // Requests taken this cycle, split by target.
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign take_st = take && !wb_we_i && wb_adr_i[ADDR_W-1:2] == `WLF_IDX_STATUS;
  assign take_len = take && wb_we_i && wb_adr_i[ADDR_W-1:2] == `WLF_IDX_LINK_EN;

  // Shadows of both enable registers, so irq checks know what is armed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wen_q <= 8'h00;
      len_q <= 8'h00;
    end else if (take && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i[ADDR_W-1:2] == `WLF_IDX_WAKE_EN) wen_q <= wb_dat_i[7:0];
      if (wb_adr_i[ADDR_W-1:2] == `WLF_IDX_LINK_EN) len_q <= wb_dat_i[7:0];
    end
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_rd_ack(idx);
    wb_ack_o && !wb_we_i && wb_adr_i[ADDR_W-1:2] == idx;
  endsequence

  property p_ack;
    take |=> s_ack_pulse;
  endproperty
  property p_dat_idle;
    !(wb_ack_o && !wb_we_i) |-> wb_dat_o == 32'h0;
  endproperty
  property p_st_rsvd;
    s_rd_ack(`WLF_IDX_STATUS) |-> wb_dat_o[31:7] == 25'h0 && wb_dat_o[3:2] == 2'h0;
  endproperty
  property p_cmd_rsvd;
    s_rd_ack(`WLF_IDX_CMD) |-> wb_dat_o[31:5] == 27'h0;
  endproperty
  property p_link_state;
    $stable(link_up_i)[*6] ##0 s_rd_ack(`WLF_IDX_STATUS) |-> wb_dat_o[1] == link_up_i;
  endproperty
  property p_magic_irq;
    magic_detect_i && wen_q[`WLF_WE_MAGIC] |-> ##[1:3] wake_irq_o;
  endproperty
  property p_pin_irq;
    $rose(external_wake_pin_i) && wen_q[`WLF_WE_PIN] |-> ##[2:6] wake_irq_o;
  endproperty
  property p_link_irq;
    $changed(link_up_i) && len_q[0] |-> ##[2:6] link_irq_o;
  endproperty
  property p_link_fall;
    $fell(link_irq_o) |-> $past(take_st) || $past(take_st, 2) || $past(take_len)
      || $past(take_len, 2);
  endproperty

  a_ack: assert property (p_ack) else $error("ack not a one-cycle pulse");
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero");
  a_st_rsvd: assert property (p_st_rsvd) else $error("status reserved bits set");
  a_cmd_rsvd: assert property (p_cmd_rsvd) else $error("command reserved bits set");
  a_link_state: assert property (p_link_state) else $error("link state wrong");
  a_magic_irq: assert property (p_magic_irq) else $error("magic wake missing");
  a_pin_irq: assert property (p_pin_irq) else $error("pin wake missing");
  a_link_irq: assert property (p_link_irq) else $error("link irq missing");
  a_link_fall: assert property (p_link_fall) else $error("link irq fell unread");
endmodule : wlf_top_checker

bind wlf_top wlf_top_checker #(.ADDR_W(ADDR_W)) u_wlf_top_checker (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .magic_detect_i, .external_wake_pin_i, .link_up_i,
  .wake_irq_o, .link_irq_o
);

// >>> bench/test_wlf_top.sv
// Self-checking bench for the wake/filter top.
`timescale 1ns/1ps
`include "wlf_defs.svh"

module test_wlf_top;
  import wlf_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [8:0] wb_adr_i = 9'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wake_irq_o, link_irq_o;
  logic rx_sof_i = 1'h0, rx_valid_i = 1'h0, rx_eof_i = 1'h0;
  wlf_byte_t rx_data_i = 8'h00;
  logic magic_detect_i = 1'h0, external_wake_pin_i = 1'h0, link_up_i = 1'h0;
  int bad_count = 0, compares = 0, cycles = 0;
  wlf_byte_t frame [96];
  bit pick [96];
  logic [31:0] rd;
  logic [7:0] oa, ob;
  wlf_mask_t ma, mb;
  logic [23:0] ea, eb, ec;
  logic [6:0] regs [15] = '{`WLF_IDX_WAKE_EN, `WLF_IDX_LINK_EN, `WLF_IDX_STATUS,
    `WLF_IDX_CMD, `WLF_IDX_A_MASK, `WLF_IDX_A_CRC, `WLF_IDX_A_OFF, `WLF_IDX_A_LB,
    `WLF_IDX_B_MASK, `WLF_IDX_B_CRC, `WLF_IDX_B_OFF, `WLF_IDX_B_LB, `WLF_IDX_MAC_LO,
    `WLF_IDX_MAC_HI, 7'h7F};

  // ----
  // Clock, timeout and design
  // ----
  // Clock of 20 ns; the cycle ceiling cuts a hung run short.
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  wlf_top u_wlf_top (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .rx_sof_i, .rx_valid_i, .rx_data_i, .rx_eof_i, .magic_detect_i,
    .external_wake_pin_i, .link_up_i, .wake_irq_o, .link_irq_o
  );

  // ----
  // Tasks and models
  // ----
  // Compares a value and counts the outcome.
  task chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  // One classic Wishbone cycle; ev pulses the magic input in the taken cycle.
  task wb(input logic we, input logic [6:0] i, input logic [31:0] d, input logic [3:0] s,
          input logic ev);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= {i, 2'h0};
    wb_sel_i <= s;
    wb_dat_i <= d;
    magic_detect_i <= ev;
    do begin
      @(posedge clk_i);
      magic_detect_i <= 1'h0;
    end while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb

  task wr(input logic [6:0] i, input logic [31:0] d);
    wb(1'h1, i, d, 4'hF, 1'h0);
  endtask : wr

  task rdc(input logic [6:0] i, input logic [31:0] e);
    wb(1'h0, i, 32'h0, 4'hF, 1'h0);
    chk(rd, e);
  endtask : rdc

  // Marks the frame bytes that a window of 32 mask bits selects.
  task mark(input bit clr, input int st, input wlf_mask_t m);
    if (clr) pick = '{default: 1'b0};
    for (int k = 0; k < 32; k++) if (m[k]) pick[st + k] = 1'b1;
  endtask : mark

  // Expected CRC-16 over the marked bytes, MSB first, and the last marked byte.
  function automatic logic [23:0] crc_lb();
    logic [15:0] c;
    logic [7:0] lb;
    c = `WLF_CRC_INIT;
    lb = 8'h00;
    for (int i = 0; i < 96; i++) if (pick[i]) begin
      lb = frame[i];
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ lb[b]) ? `WLF_CRC_POLY : 16'h0);
    end
    return {c, lb};
  endfunction : crc_lb

  task prog(input logic [6:0] base, input wlf_mask_t m, input logic [7:0] off,
            input logic [23:0] e);
    wr(base, m);
    wr(base + 7'h4, {16'h0, e[23:8]});
    wr(base + 7'h6, {24'h0, off});
    wr(base + 7'h8, {24'h0, e[7:0]});
  endtask : prog

  // Sets the command, sends the frame and reads the pattern flag.
  task pat(input logic [7:0] cmd, input logic want);
    wr(`WLF_IDX_CMD, {24'h0, cmd});
    @(posedge clk_i);
    rx_sof_i <= 1'h1;
    @(posedge clk_i);
    rx_sof_i <= 1'h0;
    for (int i = 0; i < 96; i++) begin
      rx_valid_i <= 1'h1;
      rx_data_i <= frame[i];
      @(posedge clk_i);
    end
    rx_valid_i <= 1'h0;
    rx_eof_i <= 1'h1;
    @(posedge clk_i);
    rx_eof_i <= 1'h0;
    rdc(`WLF_IDX_STATUS, want ? 32'h40 : 32'h0);
  endtask : pat

  task test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(32'h2b3951a5));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (regs[i]) rdc(regs[i], 32'h0);
    wr(7'h7F, $urandom);
    rdc(7'h7F, 32'h0);
    ma = $urandom;
    wb(1'h1, `WLF_IDX_CMD, ma, 4'hE, 1'h0);
    rdc(`WLF_IDX_CMD, 32'h0);
    wr(`WLF_IDX_CMD, ma);
    rdc(`WLF_IDX_CMD, ma & 32'h1F);
    // Magic wake, its clear on read and an event inside the clearing read.
    wr(`WLF_IDX_WAKE_EN, 32'h71);
    wr(`WLF_IDX_LINK_EN, 32'h1);
    wb(1'h0, `WLF_IDX_CMD, 32'h0, 4'hF, 1'h1);
    repeat (2) @(posedge clk_i);
    chk(wake_irq_o, 32'h1);
    rdc(`WLF_IDX_STATUS, 32'h10);
    rdc(`WLF_IDX_STATUS, 32'h0);
    wb(1'h0, `WLF_IDX_STATUS, 32'h0, 4'hF, 1'h1);
    rdc(`WLF_IDX_STATUS, 32'h10);
    wr(`WLF_IDX_WAKE_EN, 32'h61);
    wb(1'h0, `WLF_IDX_CMD, 32'h0, 4'hF, 1'h1);
    rdc(`WLF_IDX_STATUS, 32'h0);
    wr(`WLF_IDX_WAKE_EN, 32'h71);
    // External pin and link changes.
    external_wake_pin_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    rdc(`WLF_IDX_STATUS, 32'h20);
    external_wake_pin_i <= 1'h0;
    link_up_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    chk(link_irq_o, 32'h1);
    rdc(`WLF_IDX_STATUS, 32'h3);
    rdc(`WLF_IDX_STATUS, 32'h2);
    link_up_i <= 1'h0;
    repeat (8) @(posedge clk_i);
    rdc(`WLF_IDX_STATUS, 32'h1);
    // Pattern filters on a random frame whose destination is the station.
    foreach (frame[i]) frame[i] = 8'($urandom);
    wr(`WLF_IDX_MAC_LO, {frame[2], frame[3], frame[4], frame[5]});
    wr(`WLF_IDX_MAC_HI, {16'h0, frame[0], frame[1]});
    oa = 8'(3 + $urandom % 4);
    ob = 8'($urandom % 8);
    ma = $urandom | 32'h1;
    mb = $urandom | 32'h1;
    mark(1'b1, 2 * oa, ma);
    ea = crc_lb();
    mark(1'b1, 2 * ob, mb);
    eb = crc_lb();
    mark(1'b1, 2 * oa, ma);
    mark(1'b0, 2 * oa + 32 + 2 * ob, mb);
    ec = crc_lb();
    prog(`WLF_IDX_A_MASK, ma, oa, ea);
    prog(`WLF_IDX_B_MASK, mb, ob, eb ^ 24'h1);
    pat(8'h01, 1'h1);
    pat(8'h00, 1'h0);
    pat(8'h03, 1'h1);
    pat(8'h04, 1'h0);
    frame[0] ^= 8'h01;
    pat(8'h03, 1'h0);
    pat(8'h01, 1'h1);
    frame[0] ^= 8'h01;
    prog(`WLF_IDX_A_MASK, ma, oa, ea ^ 24'h100);
    prog(`WLF_IDX_B_MASK, mb, ob, eb);
    pat(8'h05, 1'h1);
    pat(8'h01, 1'h0);
    prog(`WLF_IDX_B_MASK, mb, ob, ec);
    pat(8'h15, 1'h1);
    pat(8'h05, 1'h0);
    test_done();
  end
endmodule : test_wlf_top
